// ### correlator_multiplier_array.sv
/*
 * Correlator multiplier array: offset products, split counters,
 * temporary storage with select/shift readout, AHB-Lite registers.
 * Assumes one 100 MHz clock, pins synchronised here, one bus master.
 */
// Summary of operation
// - Each sample is a two-bit code meaning minus one, zero or plus one.
// - Product is +1 for equal nonzero, -1 opposite, zero if any zero.
// - One is added to each product, giving 2, 1 or 0 up-counts.
// - Each card holds thirteen cross channels and one self channel.
// - Surplus self channels serve as redundant self multipliers.
// - Results leave as 20-bit words, 3032 per readout, by shift clock.
// - A flag rises once temporary storage holds integration data.
// - First two counter stages held cleared during blanking and dump.
// - In dump, after copying, upper counter stages are cleared.
`timescale 1ns/1ps
`default_nettype none
`include "corr_mult_map.svh"

module correlator_multiplier_array #(
    parameter int NUM_CARDS = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_CARDS*`CROSS_PER_CARD*2-1:0] sampleCrossA,
    input wire logic [NUM_CARDS*`CROSS_PER_CARD*2-1:0] sampleCrossB,
    input wire logic [NUM_CARDS*2-1:0] sampleSelf,
    input wire logic blankingInterval,
    input wire logic dumpInterval,
    input wire logic [2:0] outputGroupSelect,
    input wire logic storageShiftOutClock,
    output logic [`WORD_BITS-1:0] storageWord,
    output logic storageFullFlag,
    output logic irq
);
    import corr_pkg::*;

    localparam int NCH = NUM_CARDS * `CH_PER_CARD;
    localparam int NX = NUM_CARDS * `CROSS_PER_CARD * 2;
    localparam int HB = `WORD_BITS - `LOW_BITS;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [NX-1:0] crossA_s1, crossA_s2, crossB_s1, crossB_s2;
    logic [NUM_CARDS*2-1:0] self_s1, self_s2;
    logic [5:0] ctl_s1, ctl_s2;
    logic shift_s3;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            crossA_s1 <= '0;
            crossA_s2 <= '0;
            crossB_s1 <= '0;
            crossB_s2 <= '0;
            self_s1 <= '0;
            self_s2 <= '0;
            ctl_s1 <= 6'h00;
            ctl_s2 <= 6'h00;
            shift_s3 <= 1'b0;
        end else begin
            crossA_s1 <= sampleCrossA;
            crossA_s2 <= crossA_s1;
            crossB_s1 <= sampleCrossB;
            crossB_s2 <= crossB_s1;
            self_s1 <= sampleSelf;
            self_s2 <= self_s1;
            ctl_s1 <= {outputGroupSelect, storageShiftOutClock,
                       dumpInterval, blankingInterval};
            ctl_s2 <= ctl_s1;
            shift_s3 <= ctl_s2[2];
        end
    end

    logic blankS, dumpS, shiftEdge, dumpS3, dumpRise;
    logic [2:0] groupSel;
    assign blankS = ctl_s2[0];
    assign dumpS = ctl_s2[1];
    assign groupSel = ctl_s2[5:3];
    assign shiftEdge = ctl_s2[2] && !shift_s3;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dumpS3 <= 1'b0;
        end else begin
            dumpS3 <= dumpS;
        end
    end
    assign dumpRise = dumpS && !dumpS3;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [1:0] ctrl_reg;
    logic [`INT_BITS-1:0] intStat_reg, intMask_reg;
    logic clearPend_reg;
    logic gate, countOn;
    assign gate = blankS || dumpS;
    assign countOn = !gate && ctrl_reg[`CTRL_COUNT_EN];

    // Clear of the upper stages one cycle after the copy
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clearPend_reg <= 1'b0;
        end else begin
            clearPend_reg <= dumpRise;
        end
    end

    // ------------------------------------------------------------------
    // Multiplier channels
    // ------------------------------------------------------------------
    prod_t prodVal [NCH];
    logic [`LOW_BITS-1:0] lowCnt [NCH];
    logic [HB-1:0] highCnt [NCH];
    logic [`WORD_BITS-1:0] storeW [NCH];

    genvar gj;
    generate
        for (gj = 0; gj < NCH; gj++) begin : g_ch
            localparam int C = gj / `CH_PER_CARD;
            localparam int K = gj % `CH_PER_CARD;
            logic [1:0] a, b;
            logic [`LOW_BITS:0] sum;
            logic [`LOW_BITS-1:0] low_reg;
            logic [HB-1:0] high_reg;
            logic [`WORD_BITS-1:0] st_reg;
            if (K < `CROSS_PER_CARD) begin : g_x
                assign a = crossA_s2[(C*`CROSS_PER_CARD+K)*2 +: 2];
                assign b = crossB_s2[(C*`CROSS_PER_CARD+K)*2 +: 2];
            end else if (C % 2 == 1) begin : g_red
                // Surplus self channel backs up the neighbour card
                assign a = ctrl_reg[`CTRL_REDUNDANT] ?
                    self_s2[(C-1)*2 +: 2] : self_s2[C*2 +: 2];
                assign b = a;
            end else begin : g_self
                assign a = self_s2[C*2 +: 2];
                assign b = a;
            end
            assign prodVal[gj] = offsetProduct(a, b);
            assign sum = {1'b0, low_reg} + {1'b0, prodVal[gj]};

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    low_reg <= '0;
                end else if (gate) begin
                    low_reg <= '0;
                end else if (countOn) begin
                    low_reg <= sum[`LOW_BITS-1:0];
                end
            end

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    high_reg <= '0;
                end else if (clearPend_reg) begin
                    high_reg <= '0;
                end else if (countOn && sum[`LOW_BITS]) begin
                    high_reg <= high_reg + 1'b1;
                end
            end

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    st_reg <= '0;
                end else if (dumpRise) begin
                    st_reg <= {high_reg, low_reg};
                end
            end

            assign lowCnt[gj] = low_reg;
            assign highCnt[gj] = high_reg;
            assign storeW[gj] = st_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Multiplication count, stored with the results
    // ------------------------------------------------------------------
    logic [`WORD_BITS-1:0] multCount_reg, multStore_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            multCount_reg <= '0;
            multStore_reg <= '0;
        end else begin
            if (clearPend_reg) begin
                multCount_reg <= '0;
            end else if (countOn) begin
                multCount_reg <= multCount_reg + 1'b1;
            end
            if (dumpRise) begin
                multStore_reg <= multCount_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Readout of temporary storage
    // ------------------------------------------------------------------
    logic [11:0] readIdx_reg;
    logic full_reg, lastWord;
    assign lastWord = (readIdx_reg == 12'(`READOUT_WORDS - 1));

    function automatic logic [2:0] groupOf(input logic [11:0] idx);
        logic [2:0] g;
        g = 3'h2;
        if (idx < 12'(`GROUP_WORDS)) begin
            g = 3'h0;
        end else if (idx < 12'(2 * `GROUP_WORDS)) begin
            g = 3'h1;
        end
        return g;
    endfunction

    function automatic logic [`WORD_BITS-1:0] wordAt(
        input logic [11:0] idx);
        logic [`WORD_BITS-1:0] w;
        w = '0;
        for (int i = 0; i < NCH; i++) begin
            if (idx == 12'(i)) begin
                w = storeW[i];
            end
        end
        if (idx == 12'(NCH)) begin
            w = multStore_reg;
        end
        return w;
    endfunction

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            full_reg <= 1'b0;
            readIdx_reg <= '0;
        end else if (dumpRise) begin
            full_reg <= 1'b1;
            readIdx_reg <= '0;
        end else if (full_reg && shiftEdge) begin
            readIdx_reg <= lastWord ? 12'h000 : readIdx_reg + 12'h001;
            if (lastWord) begin
                full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            storageWord <= '0;
            storageFullFlag <= 1'b0;
        end else begin
            storageFullFlag <= full_reg;
            storageWord <= (groupSel == groupOf(readIdx_reg)) ?
                wordAt(readIdx_reg) : '0;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic addrPhase;
    logic [`INT_BITS-1:0] intEvt, w1c;
    assign addrPhase = hsel && htrans[1] && hready;
    assign intEvt = {full_reg && shiftEdge && lastWord, dumpRise};
    assign w1c = (wrPend_reg && wrAddr_reg == `OFS_INT_STAT) ?
        hwdata[`INT_BITS-1:0] : '0;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            wrAddr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `CTRL_RESET;
            intMask_reg <= `INT_MASK_RESET;
        end else if (wrPend_reg) begin
            if (wrAddr_reg == `OFS_CTRL) begin
                ctrl_reg <= hwdata[1:0];
            end
            if (wrAddr_reg == `OFS_INT_MASK) begin
                intMask_reg <= hwdata[`INT_BITS-1:0];
            end
        end
    end

    // Events win over a simultaneous clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            intStat_reg <= '0;
            irq <= 1'b0;
        end else begin
            intStat_reg <= (intStat_reg & ~w1c) | intEvt;
            irq <= |(((intStat_reg & ~w1c) | intEvt) & intMask_reg);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                `OFS_CTRL: hrdata <= {30'h0, ctrl_reg};
                `OFS_STATUS: hrdata <= {29'h0, dumpS, blankS, full_reg};
                `OFS_INT_STAT: hrdata <= {30'h0, intStat_reg};
                `OFS_INT_MASK: hrdata <= {30'h0, intMask_reg};
                `OFS_MULT_COUNT: hrdata <= {12'h0, multStore_reg};
                `OFS_READ_INDEX: hrdata <= {20'h0, readIdx_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [1:0] a0, b0;
    assign a0 = g_ch[0].a;
    assign b0 = g_ch[0].b;

    AST_EQUAL_PLUS: assert property (@(posedge clk_sys) disable iff (!nrst)
        (a0 == b0 && (a0 == SMP_POS || a0 == SMP_NEG)) |-> prodVal[0] == 2'h2)
        else $error("equal nonzero samples must give two counts");
    AST_OPPOSITE: assert property (@(posedge clk_sys) disable iff (!nrst)
        ((a0 == SMP_POS && b0 == SMP_NEG) || (a0 == SMP_NEG && b0 == SMP_POS))
        |-> prodVal[0] == 2'h0)
        else $error("opposite samples must give no count");
    AST_ZERO_LEVEL: assert property (@(posedge clk_sys) disable iff (!nrst)
        (a0 inside {2'h0, 2'h2} || b0 inside {2'h0, 2'h2})
        |-> prodVal[0] == 2'h1)
        else $error("zero sample must give one count");
    AST_LOW_HELD: assert property (@(posedge clk_sys) disable iff (!nrst)
        (blankS || dumpS) |=> lowCnt[0] == 2'h0)
        else $error("low stages not held during blank or dump");
    AST_HIGH_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
        dumpRise ##1 dumpS |=> highCnt[0] == '0 && multCount_reg == '0)
        else $error("upper stages not cleared after copy");
    AST_COPY: assert property (@(posedge clk_sys) disable iff (!nrst)
        dumpRise |=> storeW[0] == $past({highCnt[0], lowCnt[0]}))
        else $error("storage missed the counter value");
    AST_FULL_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
        dumpRise |=> full_reg ##1 storageFullFlag)
        else $error("full flag not raised after dump");
    AST_READ_DONE: assert property (@(posedge clk_sys) disable iff (!nrst)
        (full_reg && shiftEdge && lastWord && !dumpRise)
        |=> !full_reg && readIdx_reg == 12'h000)
        else $error("readout did not end after last word");
    AST_UP_ONLY: assert property (@(posedge clk_sys) disable iff (!nrst)
        !clearPend_reg |=> highCnt[0] >= $past(highCnt[0]))
        else $error("counter decreased");
    AST_MULT_COUNT: assert property (@(posedge clk_sys) disable iff (!nrst)
        (countOn && !clearPend_reg)
        |=> multCount_reg == $past(multCount_reg) + 1'b1)
        else $error("multiplication count missed a step");
    AST_WORD_GROUP: assert property (@(posedge clk_sys) disable iff (!nrst)
        (groupSel != groupOf(readIdx_reg)) |=> storageWord == '0)
        else $error("unselected group drove the word");
    if (NUM_CARDS > 1) begin : g_ast_red
        AST_REDUNDANT: assert property (@(posedge clk_sys)
            disable iff (!nrst)
            ctrl_reg[`CTRL_REDUNDANT]
            |-> prodVal[2*`CH_PER_CARD-1] == prodVal[`CH_PER_CARD-1])
            else $error("redundant self channel not tracking");
    end

endmodule
`default_nettype wire

// ### corr_mult_map.svh
/*
 * Offsets, field positions, reset values and counts of the correlator
 * multiplier array.
 * Assumes inclusion by its bare name before use.
 */
`ifndef CORR_MULT_MAP_SVH
`define CORR_MULT_MAP_SVH

// ----------------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------------
`define CROSS_PER_CARD 13
`define SELF_PER_CARD 1
`define CH_PER_CARD 14
`define READOUT_WORDS 3032
`define GROUP_WORDS 1011
`define NUM_GROUPS 3
`define WORD_BITS 20
`define LOW_BITS 2

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STAT 8'h08
`define OFS_INT_MASK 8'h0c
`define OFS_MULT_COUNT 8'h10
`define OFS_READ_INDEX 8'h14

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CTRL_COUNT_EN 0
`define CTRL_REDUNDANT 1
`define CTRL_RESET 2'h3
`define ST_FULL 0
`define ST_BLANK 1
`define ST_DUMP 2
`define INT_FULL 0
`define INT_DONE 1
`define INT_BITS 2
`define INT_MASK_RESET 2'h0

`endif

// ### corr_pkg.sv
/*
 * Types and product table of the correlator multiplier array.
 * Assumes the map header is compiled alongside it.
 */
package corr_pkg;

    // Three-level sample codes; the unused code reads as zero
    typedef enum logic [1:0] {
        SMP_ZERO = 2'h0,
        SMP_POS = 2'h1,
        SMP_NEG = 2'h3
    } sample_t;

    typedef logic [1:0] prod_t;

    // Product plus one: 2, 1 or 0 counts
    function automatic prod_t offsetProduct(input logic [1:0] a,
                                            input logic [1:0] b);
        prod_t r;
        r = 2'h1;
        if ((a == SMP_POS || a == SMP_NEG) &&
            (b == SMP_POS || b == SMP_NEG)) begin
            r = (a == b) ? 2'h2 : 2'h0;
        end
        return r;
    endfunction

endpackage

// ### corr_controller_model.sv
/*
 * System controller model: waits for the full flag, selects output
 * groups and steps the shift-out clock through every stored word.
 * Assumes the map header and a free-running clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "corr_mult_map.svh"

module corr_controller_model #(
    parameter int NCH = 28
) (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic storageFullFlag,
    input wire logic [`WORD_BITS-1:0] storageWord,
    output logic [2:0] outputGroupSelect,
    output logic storageShiftOutClock,
    output logic done
);
    logic [`WORD_BITS-1:0] words [0:`READOUT_WORDS-1];
    logic [31:0] trueVal [0:NCH-1];
    logic [`WORD_BITS-1:0] offGroup;
    logic lastFull;
    int idx;

    // ------------------------------------------------------------------
    // Readout sequence
    // ------------------------------------------------------------------
    initial begin
        outputGroupSelect = 3'h0;
        storageShiftOutClock = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go === 1'b1) begin
                while (storageFullFlag !== 1'b1) @(posedge clk_sys);
                outputGroupSelect <= 3'h1;
                repeat (5) @(posedge clk_sys);
                offGroup = storageWord;
                for (idx = 0; idx < `READOUT_WORDS; idx++) begin
                    if (outputGroupSelect !== 3'(idx / `GROUP_WORDS)) begin
                        outputGroupSelect <= 3'(idx / `GROUP_WORDS);
                        repeat (5) @(posedge clk_sys);
                    end
                    words[idx] = storageWord;
                    if (idx == `READOUT_WORDS - 1) begin
                        lastFull = storageFullFlag;
                    end
                    storageShiftOutClock <= 1'b1;
                    repeat (4) @(posedge clk_sys);
                    storageShiftOutClock <= 1'b0;
                    repeat (4) @(posedge clk_sys);
                end
                for (idx = 0; idx < NCH; idx++) begin
                    trueVal[idx] = 32'(words[idx]) - 32'(words[NCH]);
                end
                done <= 1'b1;
                while (go === 1'b1) @(posedge clk_sys);
                done <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### correlator_multiplier_array_tb.sv
/*
 * Testbench: AHB-Lite register tasks, dump/blank stimulus and two
 * integrations read out by the controller model.
 * Assumes corr_pkg, the map header and the design are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "corr_mult_map.svh"

module correlator_multiplier_array_tb;
    localparam int NC = 2;
    localparam int NCH = NC * `CH_PER_CARD;
    logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, outputGroupSelect;
    logic [NC*`CROSS_PER_CARD*2-1:0] sampleCrossA, sampleCrossB;
    logic [NC*2-1:0] sampleSelf;
    logic blankingInterval, dumpInterval, storageShiftOutClock;
    logic storageFullFlag, go, done;
    logic [`WORD_BITS-1:0] storageWord;
    logic [1:0] codes [0:3] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int miscompares = 0;
    int n_compared = 0;

    correlator_multiplier_array #(.NUM_CARDS(NC)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sampleCrossA(sampleCrossA),
        .sampleCrossB(sampleCrossB), .sampleSelf(sampleSelf),
        .blankingInterval(blankingInterval), .dumpInterval(dumpInterval),
        .outputGroupSelect(outputGroupSelect),
        .storageShiftOutClock(storageShiftOutClock),
        .storageWord(storageWord), .storageFullFlag(storageFullFlag),
        .irq(irq));

    corr_controller_model #(.NCH(NCH)) i_ctl (
        .clk_sys(clk_sys), .go(go), .storageFullFlag(storageFullFlag),
        .storageWord(storageWord), .outputGroupSelect(outputGroupSelect),
        .storageShiftOutClock(storageShiftOutClock), .done(done));

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic ahbCycle(input logic w, input logic [31:0] a,
                            input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic ahbWrite(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahbCycle(1'b1, a, d, unused);
    endtask

    task automatic ahbRead(input logic [31:0] a, output logic [31:0] r);
        ahbCycle(1'b0, a, 32'h0, r);
    endtask

    task automatic dumpPulse;
        @(posedge clk_sys);
        dumpInterval <= 1'b1;
        repeat (5) @(posedge clk_sys);
        blankingInterval <= 1'b1;
        dumpInterval <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic runReadout;
        @(posedge clk_sys);
        go <= 1'b1;
        while (done !== 1'b1) @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
    endtask

    function automatic int offs(input logic [1:0] a, input logic [1:0] b);
        if (a == 2'h0 || a == 2'h2 || b == 2'h0 || b == 2'h2) return 1;
        return (a == b) ? 2 : 0;
    endfunction

    task automatic checkRun(input logic redund, input logic lost,
                            input int z, input int lo, input int hi);
        int cnt, p, card, k, n, ch, e;
        logic [1:0] s;
        logic [31:0] r;
        cnt = int'(i_ctl.words[NCH]);
        check(32'((cnt >= lo) && (cnt <= hi)), 32'h1);
        ahbRead(`OFS_MULT_COUNT, r);
        check(r, 32'(cnt));
        for (ch = 0; ch < NCH; ch++) begin
            card = ch / `CH_PER_CARD;
            k = ch % `CH_PER_CARD;
            n = card * `CROSS_PER_CARD + k;
            if (k < `CROSS_PER_CARD) begin
                p = offs(codes[n % 4], codes[(n / 4) % 4]);
            end else begin
                s = (card == 1 && redund) ? sampleSelf[1:0] :
                    sampleSelf[2*card+:2];
                p = offs(s, s);
            end
            e = lost ? (p * cnt / 4) * 4 : p * (cnt - z) + z;
            check(32'(i_ctl.words[ch]), 32'(e));
            check(i_ctl.trueVal[ch], 32'(e - cnt));
        end
        for (ch = NCH + 1; ch < `READOUT_WORDS; ch++) begin
            check(32'(i_ctl.words[ch]), 32'h0);
        end
        check(32'(i_ctl.lastFull), 32'h1);
        check(32'(storageFullFlag), 32'h0);
        check(32'(i_ctl.offGroup), 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        blankingInterval = 1'b0;
        dumpInterval = 1'b0;
        go = 1'b0;
        sampleSelf = {2'h0, 2'h3};
        for (int i = 0; i < NC * `CROSS_PER_CARD; i++) begin
            sampleCrossA[2*i+:2] = codes[i % 4];
            sampleCrossB[2*i+:2] = codes[(i / 4) % 4];
        end
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(32'(storageFullFlag), 32'h0);
        ahbRead(`OFS_CTRL, rd);
        check(rd, 32'h3);
        ahbRead(`OFS_INT_MASK, rd);
        check(rd, 32'h0);
        ahbRead(32'h40, rd);
        check(rd, 32'h0);
        ahbWrite(`OFS_INT_MASK, 32'h1);
        repeat (200) @(posedge clk_sys);
        dumpPulse();
        check(32'(storageFullFlag), 32'h1);
        check(32'(irq), 32'h1);
        ahbRead(`OFS_INT_STAT, rd);
        check(rd, 32'h1);
        ahbRead(`OFS_STATUS, rd);
        check(rd, 32'h3);
        ahbWrite(`OFS_INT_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        check(32'(irq), 32'h0);
        runReadout();
        checkRun(1'b1, 1'b0, 2, 1, 90000);
        ahbRead(`OFS_INT_STAT, rd);
        check(rd, 32'h2);
        ahbRead(`OFS_READ_INDEX, rd);
        check(rd, 32'h0);
        check(32'(hresp), 32'h0);
        check(32'(irq), 32'h0);
        ahbWrite(`OFS_INT_MASK, 32'h3);
        repeat (2) @(posedge clk_sys);
        check(32'(irq), 32'h1);
        ahbWrite(`OFS_INT_STAT, 32'h2);
        repeat (2) @(posedge clk_sys);
        check(32'(irq), 32'h0);
        ahbWrite(`OFS_CTRL, 32'h1);
        blankingInterval <= 1'b0;
        repeat (150) @(posedge clk_sys);
        blankingInterval <= 1'b1;
        repeat (100) @(posedge clk_sys);
        dumpPulse();
        runReadout();
        checkRun(1'b0, 1'b1, 0, 145, 155);
        results();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        miscompares++;
        results();
    end

endmodule
`default_nettype wire
